/* File: serial_link_config.sv */
/*
  Transmit link configuration: register file, quick-setup decode, lane
  rate check, serializer lock model and a bit-serial lane output.
  Assumes a synchronous register port and samples synchronous to ref_clk.
*/
// How it works
// - one link owns all four lanes
// - quick code sets lanes, converters, octets together
// - M counts virtual converters with downconverters
// - lane rate equals M*N'*10/8*fout/L
// - fout is converter clock over decimation
// - 16-bit one/two converter code table
// - 16-bit four/eight converter code table
// - 8-bit one converter code table
// - 8-bit two converter code table
// - K multiple of 4, F-dependent minimum, max 32
// - serializer lock shown at status bit 7
`timescale 1ns/100ps
module serial_link_config
  import link_cfg_pkg::*;
#(
  parameter int LANES = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [11:0] adc_clk_mhz,
  input  wire logic        sample_valid,
  output logic             sample_ready,
  input  wire logic [15:0] sample_data,
  output logic             serial_lane_out_0,
  output logic             serial_lane_out_1,
  output logic             serial_lane_out_2,
  output logic             serial_lane_out_3,
  output logic             pll_locked
);
  import link_cfg_pkg::*;

  logic [7:0]  decimation_factor_select_reg, lane_rate_control_reg, link_quick_setup_reg;
  logic [7:0]  link_ctrl_reg, kmf_reg;
  logic [7:0]  act_code_reg, act_decim_reg, act_kmf_reg, act_rate_reg;
  logic        act_word8_reg;
  link_state_t state_reg, state_next;
  logic [15:0] lock_cnt_reg;
  logic [15:0] shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  rdata_next;
  logic [LANES-1:0] lane_active;
  logic [17:0] cfg;

  // {valid, L[2:0], M[3:0], F[4:0], S[3:0], HD}
  function automatic logic [17:0] decode(input logic w8, input logic [7:0] c);
    logic [17:0] r;
    r = '0;
    if (!w8) begin
      case (c)
        8'h01: r = {1'b1, 3'd1, 4'd1, 5'd2,  4'd1, 1'b0};
        8'h40: r = {1'b1, 3'd2, 4'd1, 5'd1,  4'd1, 1'b1};
        8'h41: r = {1'b1, 3'd2, 4'd1, 5'd2,  4'd2, 1'b0};
        8'h80: r = {1'b1, 3'd4, 4'd1, 5'd1,  4'd2, 1'b1};
        8'h81: r = {1'b1, 3'd4, 4'd1, 5'd2,  4'd4, 1'b0};
        8'h0A: r = {1'b1, 3'd1, 4'd2, 5'd4,  4'd1, 1'b0};
        8'h49: r = {1'b1, 3'd2, 4'd2, 5'd2,  4'd1, 1'b0};
        8'h88: r = {1'b1, 3'd4, 4'd2, 5'd1,  4'd1, 1'b1};
        8'h89: r = {1'b1, 3'd4, 4'd2, 5'd2,  4'd2, 1'b0};
        8'h13: r = {1'b1, 3'd1, 4'd4, 5'd8,  4'd1, 1'b0};
        8'h52: r = {1'b1, 3'd2, 4'd4, 5'd4,  4'd1, 1'b0};
        8'h91: r = {1'b1, 3'd4, 4'd4, 5'd2,  4'd1, 1'b0};
        8'h1C: r = {1'b1, 3'd1, 4'd8, 5'd16, 4'd1, 1'b0};
        8'h5B: r = {1'b1, 3'd2, 4'd8, 5'd8,  4'd1, 1'b0};
        8'h9A: r = {1'b1, 3'd4, 4'd8, 5'd4,  4'd1, 1'b0};
        default: r = '0;
      endcase
    end else begin
      case (c)
        8'h00: r = {1'b1, 3'd1, 4'd1, 5'd1, 4'd1, 1'b0};
        8'h01: r = {1'b1, 3'd1, 4'd1, 5'd2, 4'd2, 1'b0};
        8'h40: r = {1'b1, 3'd2, 4'd1, 5'd1, 4'd2, 1'b0};
        8'h41: r = {1'b1, 3'd2, 4'd1, 5'd2, 4'd4, 1'b0};
        8'h42: r = {1'b1, 3'd2, 4'd1, 5'd4, 4'd8, 1'b0};
        8'h80: r = {1'b1, 3'd4, 4'd1, 5'd1, 4'd4, 1'b0};
        8'h81: r = {1'b1, 3'd4, 4'd1, 5'd2, 4'd8, 1'b0};
        8'h09: r = {1'b1, 3'd1, 4'd2, 5'd2, 4'd1, 1'b0};
        8'h48: r = {1'b1, 3'd2, 4'd2, 5'd1, 4'd1, 1'b0};
        8'h49: r = {1'b1, 3'd2, 4'd2, 5'd2, 4'd2, 1'b0};
        8'h88: r = {1'b1, 3'd4, 4'd2, 5'd1, 4'd2, 1'b0};
        8'h89: r = {1'b1, 3'd4, 4'd2, 5'd2, 4'd4, 1'b0};
        8'h8A: r = {1'b1, 3'd4, 4'd2, 5'd4, 4'd8, 1'b0};
        default: r = '0;
      endcase
    end
    return r;
  endfunction : decode

  // decoded active parameter set, M counts virtual converters
  wire        cfg_valid = cfg[17];
  wire [2:0]  lanes_l   = cfg[16:14];
  wire [3:0]  conv_m    = cfg[13:10];
  wire [4:0]  octets_f  = cfg[9:5];
  assign cfg = decode(act_word8_reg, act_code_reg);

  // lane rate compared without division: M*N'*10*fadc vs limit*8*L*decim
  // a zero ratio would zero the limits, so it is taken as one
  wire [7:0]  decim_ratio = (act_decim_reg == 8'h00) ? 8'h01 : act_decim_reg;
  wire [31:0] nprime    = act_word8_reg ? 32'd8 : 32'd16;
  wire [31:0] rate_num  = 32'(conv_m) * nprime * CODE_NUM * 32'(adc_clk_mhz);
  wire [31:0] rate_den  = CODE_DEN * 32'(lanes_l) * 32'(decim_ratio);
  wire        rate_ok   = rate_num >= RATE_MIN_MBPS * rate_den &&
                          rate_num <= RATE_MAX_MBPS * rate_den;
  wire        low_req   = rate_num < RATE_LOW_MBPS * rate_den;
  // rate control bit must agree with the computed rate to lock
  wire        rate_match = act_rate_reg[LOW_RATE_BIT] == low_req;

  // multiframe length check against F
  wire [7:0]  k_min = (octets_f == 5'd1) ? K_MIN_F1 :
                      (octets_f == 5'd2) ? K_MIN_F2 :
                      (octets_f == 5'd4) ? K_MIN_F4 : K_MIN_F8;
  wire        k_ok  = act_kmf_reg[1:0] == 2'b00 && act_kmf_reg <= K_MAX &&
                      act_kmf_reg >= k_min;
  wire        link_good = cfg_valid && rate_ok && rate_match && k_ok;
  wire        pwdn      = link_ctrl_reg[PWDN_BIT];
  wire        lock_done = lock_cnt_reg == 16'(PLL_LOCK_CYC);

  // register writes; the powered-down bit is the only live control
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      decimation_factor_select_reg <= DECIMATION_RST;
      lane_rate_control_reg        <= RATE_CTRL_RST;
      link_quick_setup_reg         <= QUICK_RST;
      link_ctrl_reg                <= LINK_CTRL_RST;
      kmf_reg                      <= KMF_RST;
    end else if (reg_wr) begin
      if (reg_addr == DECIMATION_ADDR) decimation_factor_select_reg <= reg_wdata;
      if (reg_addr == RATE_CTRL_ADDR)  lane_rate_control_reg        <= reg_wdata;
      if (reg_addr == QUICK_ADDR)      link_quick_setup_reg         <= reg_wdata;
      if (reg_addr == LINK_CTRL_ADDR)  link_ctrl_reg                <= reg_wdata;
      if (reg_addr == KMF_ADDR)        kmf_reg                      <= reg_wdata;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr)
      DECIMATION_ADDR: rdata_next = decimation_factor_select_reg;
      RATE_CTRL_ADDR:  rdata_next = lane_rate_control_reg;
      PLL_STAT_ADDR: begin
        rdata_next[PLL_LOCK_BIT]  = pll_locked;
        rdata_next[ST_VALID_BIT]  = cfg_valid;
        rdata_next[ST_RANGE_BIT]  = rate_ok;
        rdata_next[ST_LOWREQ_BIT] = low_req;
        rdata_next[ST_KOK_BIT]    = k_ok;
      end
      QUICK_ADDR:     rdata_next = link_quick_setup_reg;
      LINK_CTRL_ADDR: rdata_next = link_ctrl_reg;
      KMF_ADDR:       rdata_next = kmf_reg;
      default:        rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst)         reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rdata_next;
  end

  // link state: down, waiting for serializer lock, up
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_DOWN:    if (!pwdn) state_next = ST_LOCKING;
      ST_LOCKING: begin
        if (pwdn)                        state_next = ST_DOWN;
        else if (lock_done && link_good) state_next = ST_UP;
      end
      ST_UP:      if (pwdn) state_next = ST_DOWN;
      default:    state_next = ST_DOWN;
    endcase
  end

  // shadow config loads only on leaving power-down
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg     <= ST_DOWN;
      act_code_reg  <= QUICK_RST;
      act_decim_reg <= DECIMATION_RST;
      act_kmf_reg   <= KMF_RST;
      act_rate_reg  <= RATE_CTRL_RST;
      act_word8_reg <= LINK_CTRL_RST[WORD8_BIT];
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_DOWN && !pwdn) begin
        act_code_reg  <= link_quick_setup_reg;
        act_decim_reg <= decimation_factor_select_reg;
        act_kmf_reg   <= kmf_reg;
        act_rate_reg  <= lane_rate_control_reg;
        act_word8_reg <= link_ctrl_reg[WORD8_BIT];
      end
    end
  end

  // lock settle time; holds at the end if the setup cannot lock
  always_ff @(posedge ref_clk) begin
    if (rst || state_reg != ST_LOCKING) lock_cnt_reg <= 16'h0000;
    else if (!lock_done)                lock_cnt_reg <= lock_cnt_reg + 16'h0001;
  end

  assign pll_locked = state_reg == ST_UP;

  // sample path: fifo drained one word per 16 bit times while up
  wire        drain_ready = pll_locked && bit_cnt_reg == 4'h0;
  wire        fifo_valid;
  wire [15:0] fifo_data;

  sample_fifo #(.WIDTH(16), .DEPTH(8)) sample_fifo_i (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_data),
    .out_valid (fifo_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_data)
  );

  // idle word is zero when the fifo runs dry
  always_ff @(posedge ref_clk) begin
    if (rst || !pll_locked) begin
      shift_reg   <= 16'h0000;
      bit_cnt_reg <= 4'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (drain_ready) shift_reg <= fifo_valid ? fifo_data : 16'h0000;
      else             shift_reg <= {shift_reg[14:0], 1'b0};
    end
  end

  // all lanes belong to the one link; the first L carry data
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_active[i] = pll_locked && (i < int'(lanes_l));
  end
  assign serial_lane_out_0 = lane_active[0] & shift_reg[15];
  assign serial_lane_out_1 = lane_active[1] & shift_reg[15];
  assign serial_lane_out_2 = lane_active[2] & shift_reg[15];
  assign serial_lane_out_3 = lane_active[3] & shift_reg[15];

  sequence s_power_up;
    state_reg == ST_DOWN && !pwdn;
  endsequence
  sequence s_lock_start;
    $rose(state_reg == ST_LOCKING);
  endsequence

  a_lanes_quiet_down: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg != ST_UP |-> lane_active == '0) else $error("lane active while down");
  a_single_link_mask: assert property (@(posedge ref_clk) disable iff (rst)
    lane_active inside {4'h0, 4'h1, 4'h3, 4'hF}) else $error("lane mask not one link");
  a_config_on_power: assert property (@(posedge ref_clk) disable iff (rst)
    s_power_up |=> act_code_reg == $past(link_quick_setup_reg))
    else $error("config not taken");
  a_hold_while_up: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == ST_UP && $past(state_reg == ST_UP) |-> $stable(act_code_reg))
    else $error("config changed while up");
  a_up_needs_rate: assert property (@(posedge ref_clk) disable iff (rst)
    pll_locked |-> rate_ok && rate_match && k_ok) else $error("up with bad rate");
  a_lock_settle: assert property (@(posedge ref_clk) disable iff (rst)
    s_lock_start |-> !pll_locked [*8]) else $error("lock too early");
  a_bad_code_down: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_valid |-> !pll_locked && lane_active == '0) else $error("unlisted code ran");
  a_virtual_m: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_valid |-> conv_m inside {4'd1, 4'd2, 4'd4, 4'd8}) else $error("bad converter count");
  a_decim_shadow_load: assert property (@(posedge ref_clk) disable iff (rst)
    s_power_up |=> act_decim_reg == $past(decimation_factor_select_reg))
    else $error("decimation not taken");
  a_code_88: assert property (@(posedge ref_clk) disable iff (rst)
    act_code_reg == 8'h88 && !act_word8_reg |-> cfg[16:0] == {3'd4, 4'd2, 5'd1, 4'd1, 1'b1})
    else $error("code 0x88 decode");
  a_k_limit: assert property (@(posedge ref_clk) disable iff (rst)
    k_ok |-> act_kmf_reg <= K_MAX && act_kmf_reg[1:0] == 2'b00) else $error("bad K");
endmodule : serial_link_config

/* File: link_cfg_pkg.sv */
/*
  Shared constants for the serial link configuration block: register
  offsets, field positions, reset values, lane-rate limits and timing.
  Assumes a 200 MHz ref_clk and an 8-bit register port with 12-bit offsets.
*/
package link_cfg_pkg;
  // register offsets
  localparam logic [11:0] DECIMATION_ADDR = 12'h201;
  localparam logic [11:0] RATE_CTRL_ADDR = 12'h56E;
  localparam logic [11:0] PLL_STAT_ADDR  = 12'h56F;
  localparam logic [11:0] QUICK_ADDR     = 12'h570;
  localparam logic [11:0] LINK_CTRL_ADDR = 12'h571;
  localparam logic [11:0] KMF_ADDR       = 12'h572;
  // reset values
  localparam logic [7:0]  DECIMATION_RST = 8'h01;
  localparam logic [7:0]  RATE_CTRL_RST  = 8'h00;
  localparam logic [7:0]  QUICK_RST      = 8'h88;
  localparam logic [7:0]  LINK_CTRL_RST  = 8'h00;
  localparam logic [7:0]  KMF_RST        = 8'h20;
  // field positions
  localparam int          LOW_RATE_BIT   = 4;
  localparam int          PLL_LOCK_BIT   = 7;
  localparam int          PWDN_BIT       = 0;
  localparam int          WORD8_BIT      = 1;
  localparam int          ST_VALID_BIT   = 0;
  localparam int          ST_RANGE_BIT   = 1;
  localparam int          ST_LOWREQ_BIT  = 2;
  localparam int          ST_KOK_BIT     = 3;
  // lane rate limits in Mbps and line code ratio
  localparam logic [31:0] RATE_MIN_MBPS  = 32'd3125;
  localparam logic [31:0] RATE_LOW_MBPS  = 32'd6250;
  localparam logic [31:0] RATE_MAX_MBPS  = 32'd12500;
  localparam logic [31:0] CODE_NUM       = 32'd10;
  localparam logic [31:0] CODE_DEN       = 32'd8;
  // multiframe limits
  localparam logic [7:0]  K_MAX          = 8'h20;
  localparam logic [7:0]  K_MIN_F1       = 8'h14;
  localparam logic [7:0]  K_MIN_F2       = 8'h0C;
  localparam logic [7:0]  K_MIN_F4       = 8'h08;
  localparam logic [7:0]  K_MIN_F8       = 8'h04;
  // timing
  localparam int          CLK_MHZ        = 200;
  localparam int          PLL_LOCK_NS    = 1000;
  localparam int          PLL_LOCK_CYC   = PLL_LOCK_NS * CLK_MHZ / 1000;
  localparam int          WORD_BITS      = 16;

  typedef enum logic [1:0] {ST_DOWN, ST_LOCKING, ST_UP} link_state_t;
endpackage : link_cfg_pkg

/* File: sample_fifo.sv */
/*
  Small synchronous FIFO holding samples ahead of the lane serializer.
  Assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              push;
  wire              pop;

  // extra pointer bit tells full from empty
  assign in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  // storage
  always_ff @(posedge ref_clk) begin
    if (push) mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end

  // pointers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : sample_fifo

/* File: lane_rx_model.sv */
/*
  Receiver model for the four transmit lanes: rebuilds 16-bit words from
  lane 0, msb first, and flags any lane that differs from lane 0.
  Assumes every word sent has its msb set and that idle lanes sit low.
*/
`timescale 1ns/100ps
module lane_rx_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  lanes,
  input  wire logic        locked,
  output logic             word_stb,
  output logic      [15:0] word_data,
  output logic             lane_err
);
  logic        busy;
  logic [3:0]  cnt;
  logic [14:0] sh;

  // a set bit while idle starts a word; a zero msb would be taken for idle
  always @(posedge ref_clk) begin
    word_stb <= 1'b0;
    if (rst) begin
      lane_err <= 1'b0;
    end
    if (rst || !locked) begin
      busy <= 1'b0;
      cnt  <= 4'h0;
    end else begin
      if (lanes !== {4{lanes[0]}}) begin
        lane_err <= 1'b1;
      end
      if (busy || lanes[0] === 1'b1) begin
        busy <= (cnt != 4'hF);
        cnt  <= cnt + 4'h1;
        sh   <= {sh[13:0], lanes[0]};
        if (cnt == 4'hF) begin
          word_data <= {sh, lanes[0]};
          word_stb  <= 1'b1;
        end
      end
    end
  end
endmodule : lane_rx_model

/* File: serial_link_config_tb_top.sv */
/*
  Testbench for the link configuration block: register reset values,
  sample path through the fifo to the lanes, and quick-setup decoding.
  Assumes a registered read port and the lock settle count of the package.
*/
`timescale 1ns/100ps
module serial_link_config_tb_top;
  import link_cfg_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        sample_valid = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [11:0] adc_clk_mhz = 12'd1000;
  logic [7:0]  reg_wdata = 8'h00;
  logic [15:0] sample_data = 16'h0000;
  logic [7:0]  reg_rdata;
  logic [7:0]  rd;
  logic [3:0]  lanes;
  logic        sample_ready;
  logic        pll_locked;
  logic        word_stb;
  logic        lane_err;
  logic        rdy;
  logic [15:0] word_data;
  logic [15:0] rx_q[$];
  int          mismatches = 0;
  int          total_checks = 0;
  int          n;
  logic [19:0] rst_tab [6] = '{20'h20101, 20'h56E00, 20'h57088, 20'h57100, 20'h57220, 20'h12300};
  logic [7:0]  c16 [15] = '{8'h01, 8'h40, 8'h41, 8'h80, 8'h81, 8'h0A, 8'h49, 8'h88,
                            8'h89, 8'h13, 8'h52, 8'h91, 8'h1C, 8'h5B, 8'h9A};
  logic [7:0]  c8 [13] = '{8'h00, 8'h01, 8'h40, 8'h41, 8'h42, 8'h80, 8'h81, 8'h09,
                           8'h48, 8'h49, 8'h88, 8'h89, 8'h8A};

  always #2.5 ref_clk = ~ref_clk;

  serial_link_config serial_link_config_i (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_clk_mhz(adc_clk_mhz), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .serial_lane_out_0(lanes[0]), .serial_lane_out_1(lanes[1]),
    .serial_lane_out_2(lanes[2]), .serial_lane_out_3(lanes[3]), .pll_locked(pll_locked)
  );

  lane_rx_model lane_rx_model_i (
    .ref_clk(ref_clk), .rst(rst), .lanes(lanes), .locked(pll_locked),
    .word_stb(word_stb), .word_data(word_data), .lane_err(lane_err)
  );

  // words seen by the receiver, in arrival order
  always @(posedge ref_clk) begin
    if (word_stb === 1'b1) begin
      rx_q.push_back(word_data);
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // read data is registered and holds, so sampling one cycle late is safe
  task automatic reg_read(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic run_cfg(input logic [7:0] ctl, code, decim, rate, k, st, msk);
    reg_write(LINK_CTRL_ADDR, ctl | 8'h01);
    repeat (3) @(posedge ref_clk);
    #1 check(16'({lanes, pll_locked}), 16'h0000);
    reg_write(QUICK_ADDR, code);
    reg_write(DECIMATION_ADDR, decim);
    reg_write(RATE_CTRL_ADDR, rate);
    reg_write(KMF_ADDR, k);
    reg_write(LINK_CTRL_ADDR, ctl);
    repeat (PLL_LOCK_CYC + 10) @(posedge ref_clk);
    reg_read(PLL_STAT_ADDR, rd);
    check(16'(rd & msk), 16'(st & msk));
    if (msk[PLL_LOCK_BIT]) check(16'(pll_locked), 16'(st[PLL_LOCK_BIT]));
  endtask : run_cfg

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // about 11k cycles expected; cut off well beyond that
  initial begin
    #150000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    reg_write(12'h123, 8'hFF);
    foreach (rst_tab[i]) begin
      reg_read(rst_tab[i][19:8], rd);
      check(16'(rd), 16'(rst_tab[i][7:0]));
    end
    $display("test reset done");
    // fill the fifo while the link is still locking, so nothing drains
    n = 0;
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      sample_data <= 16'h8000 + 16'(i * 16'h0F01);
      #1 rdy = sample_ready;
      @(posedge ref_clk);
      if (rdy === 1'b1) n++;
    end
    sample_valid <= 1'b0;
    check(16'(n), 16'd8);
    for (int w = 0; w < 400 && pll_locked !== 1'b1; w++) @(posedge ref_clk);
    for (int w = 0; w < 300 && rx_q.size() < 8; w++) @(posedge ref_clk);
    check(16'(rx_q.size()), 16'd8);
    foreach (rx_q[i]) check(rx_q[i], 16'h8000 + 16'(i * 16'h0F01));
    check(16'(lane_err), 16'h0000);
    reg_read(PLL_STAT_ADDR, rd);
    check(16'(rd), 16'h008B);
    $display("test stream done");
    // config written while up must not disturb the running link
    reg_write(QUICK_ADDR, 8'h02);
    reg_write(PLL_STAT_ADDR, 8'h00);
    repeat (20) @(posedge ref_clk);
    reg_read(PLL_STAT_ADDR, rd);
    check(16'(rd), 16'h008B);
    $display("test live write done");
    run_cfg(8'h00, 8'h1C, 8'h10, 8'h00, 8'h20, 8'h8B, 8'h8F);
    run_cfg(8'h00, 8'h88, 8'h00, 8'h00, 8'h20, 8'h8B, 8'h8F);
    run_cfg(8'h00, 8'h5B, 8'h10, 8'h10, 8'h20, 8'h8F, 8'h8F);
    run_cfg(8'h00, 8'h5B, 8'h10, 8'h00, 8'h20, 8'h0F, 8'h8F);
    run_cfg(8'h00, 8'h01, 8'h02, 8'h00, 8'h08, 8'h03, 8'h8F);
    run_cfg(8'h00, 8'h88, 8'h01, 8'h00, 8'h10, 8'h03, 8'h8F);
    run_cfg(8'h00, 8'h88, 8'h01, 8'h00, 8'h14, 8'h8B, 8'h8F);
    run_cfg(8'h00, 8'h1C, 8'h10, 8'h00, 8'h04, 8'h8B, 8'h8F);
    run_cfg(8'h00, 8'h88, 8'h04, 8'h10, 8'h20, 8'h0D, 8'h8F);
    run_cfg(8'h00, 8'h01, 8'h01, 8'h00, 8'h20, 8'h09, 8'h8F);
    run_cfg(8'h00, 8'h02, 8'h01, 8'h00, 8'h20, 8'h00, 8'h81);
    run_cfg(8'h02, 8'h8A, 8'h01, 8'h10, 8'h20, 8'h8F, 8'h8F);
    run_cfg(8'h02, 8'h42, 8'h01, 8'h10, 8'h20, 8'h8F, 8'h8F);
    run_cfg(8'h02, 8'h13, 8'h01, 8'h00, 8'h20, 8'h00, 8'h81);
    $display("test decode done");
    // rate boundaries at 12500, 6250 and 3125 Mbps
    @(posedge ref_clk);
    adc_clk_mhz <= 12'd1250;
    run_cfg(8'h00, 8'h88, 8'h01, 8'h00, 8'h20, 8'h8B, 8'h8F);
    run_cfg(8'h00, 8'h88, 8'h02, 8'h00, 8'h20, 8'h8B, 8'h8F);
    run_cfg(8'h00, 8'h88, 8'h04, 8'h10, 8'h20, 8'h8F, 8'h8F);
    $display("test boundary done");
    foreach (c16[i]) run_cfg(8'h00, c16[i], 8'h01, 8'h00, 8'h20, 8'h01, 8'h01);
    foreach (c8[i]) run_cfg(8'h02, c8[i], 8'h01, 8'h00, 8'h20, 8'h01, 8'h01);
    $display("test code tables done");
    report_and_stop();
  end
endmodule : serial_link_config_tb_top
